// ### core/rc_tick_divider.sv
// Free-running divider that stands in for the dedicated watchdog RC oscillator.
`timescale 1ns/1ns
`default_nettype none
module rc_tick_divider
    import watchdog_pkg::*;
(
    // Clock and reset.
    input  wire logic clock,
    input  wire logic reset_n,
    // One-cycle tick of the RC time base.
    output logic      rc_tick
);

    logic [RC_DIV_W-1:0] div_cnt_r;  // Cycles since the last tick.

    // The divider ignores sleep and every command so the time base never stops.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt_r <= '0;
        end else if (div_cnt_r == RC_DIV_W'(RC_DIV_CYCLES - 1)) begin
            div_cnt_r <= '0;
        end else begin
            div_cnt_r <= div_cnt_r + RC_DIV_W'(1);
        end
    end

    // The tick marks the last cycle of each divider period.
    assign rc_tick = (div_cnt_r == RC_DIV_W'(RC_DIV_CYCLES - 1));

endmodule : rc_tick_divider
`default_nettype wire

// ### core/watchdog_pkg.sv
// Package with the constants, types and register map of the watchdog timeout unit.
package watchdog_pkg;

    // Clock rate of the single system clock, in hertz.
    localparam int CLK_HZ             = 25_000_000;
    // Nominal watchdog period without a postscaler, in milliseconds.
    localparam int BASE_PERIOD_MS     = 18;
    // Nominal watchdog period expressed in system clock cycles.
    localparam int BASE_PERIOD_CYCLES = BASE_PERIOD_MS * (CLK_HZ / 1000);
    // System clock cycles per tick of the modelled dedicated RC oscillator.
    localparam int RC_DIV_CYCLES      = 16;
    // Width of the RC tick divider counter.
    localparam int RC_DIV_W           = 4;
    // Width of the watchdog tick counter.
    localparam int TICK_W             = 20;
    // Width of the postscaler counter, enough for a 1:128 ratio.
    localparam int PS_W               = 7;
    // Width of the postscaler ratio select field.
    localparam int PS_SEL_W           = 3;

    // AXI4-Lite data and address widths.
    localparam int AXI_DATA_W         = 32;
    localparam int AXI_ADDR_W         = 32;
    // AXI response codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_CMD     = 8'h04;
    localparam logic [7:0] OFS_STATUS  = 8'h08;
    localparam logic [7:0] OFS_COUNT   = 8'h0c;

    // Control register field positions.
    localparam int CTRL_PS_ASSIGN_BIT = 0;
    localparam int CTRL_PS_SEL_LSB    = 1;
    // Command register field positions.
    localparam int CMD_CLEAR_BIT      = 0;
    localparam int CMD_SLEEP_BIT      = 1;
    // Status register field positions.
    localparam int STAT_TIMEOUT_BIT   = 0;
    localparam int STAT_ASLEEP_BIT    = 1;
    localparam int STAT_FUSE_BIT      = 2;

    // Control register reset values.
    localparam logic                RST_PS_ASSIGN = 1'b0;
    localparam logic [PS_SEL_W-1:0] RST_PS_SEL    = 3'h0;
    // Timeout flag value after power-on reset.
    localparam logic                RST_TIMEOUT   = 1'b1;

    // Software-visible control fields.
    typedef struct packed {
        logic [PS_SEL_W-1:0] ps_sel;     // Postscaler ratio is 2 to the power ps_sel.
        logic                ps_assign;  // Postscaler is assigned to the watchdog.
    } watchdog_ctrl_t;

    // Processor run state as seen by the watchdog.
    typedef enum logic {
        ST_RUN,
        ST_SLEEP
    } run_state_t;

endpackage : watchdog_pkg

// ### core/watchdog_timeout_unit.sv
// Watchdog timeout unit with an AXI4-Lite register port.
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
//
// Function
// - Watchdog counts on its own free-running time base.
// - Expiry while running requests a device reset.
// - Expiry while asleep wakes instead of resetting.
// - Cleared enable fuse keeps watchdog fully inactive.
// - Base timeout is about eighteen milliseconds.
// - Software assigns postscaler up to one to 128.
// - Clear and sleep commands restart counter, postscaler.
// - Every expiry clears the timeout flag.
// - Power-on reset sets the timeout flag.
module watchdog_timeout_unit
    import watchdog_pkg::*;
#(
    parameter int BASE_TIMEOUT_CYCLES = BASE_PERIOD_CYCLES  // Base period in clock cycles.
) (
    // Clock and reset.
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    // Configuration fuse and wake sources.
    input  wire logic                  watchdog_enable_fuse,
    input  wire logic                  other_wake,
    // AXI4-Lite write address channel.
    input  wire logic [AXI_ADDR_W-1:0] awaddr,
    input  wire logic [2:0]            awprot,
    input  wire logic                  awvalid,
    output logic                       awready,
    // AXI4-Lite write data channel.
    input  wire logic [AXI_DATA_W-1:0] wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    // AXI4-Lite write response channel.
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    // AXI4-Lite read address channel.
    input  wire logic [AXI_ADDR_W-1:0] araddr,
    input  wire logic [2:0]            arprot,
    input  wire logic                  arvalid,
    output logic                       arready,
    // AXI4-Lite read data channel.
    output logic [AXI_DATA_W-1:0]      rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    // Watchdog actions toward the core.
    output logic                       watchdog_reset,
    output logic                       watchdog_wake
);

    // Number of RC ticks in one base watchdog period.
    localparam logic [TICK_W-1:0] TICK_LIMIT = TICK_W'(BASE_TIMEOUT_CYCLES / RC_DIV_CYCLES);

    // Fuse synchroniser stages.
    logic                  fuse_meta_r;     // First stage, read only by the second.
    logic                  fuse_r;          // Synchronised fuse level.
    // Register state.
    watchdog_ctrl_t        ctrl_r;          // Postscaler assignment and ratio.
    logic                  timeout_flag_r;  // Low after a watchdog expiry.
    run_state_t            state_r;         // Running or asleep.
    logic [TICK_W-1:0]     tick_count_r;    // Watchdog counter in RC ticks.
    logic                  reset_out_r;     // Registered reset request.
    logic                  wake_out_r;      // Registered wake request.
    // AXI write side.
    logic                  awready_r;       // Write address channel ready.
    logic                  wready_r;        // Write data channel ready.
    logic                  aw_held_r;       // A write address is held.
    logic                  w_held_r;        // Write data are held.
    logic [7:0]            waddr_r;         // Held write byte address.
    logic [AXI_DATA_W-1:0] wdata_r;         // Held write data.
    logic [3:0]            wstrb_r;         // Held byte enables.
    logic                  bvalid_r;        // Write response valid.
    logic [1:0]            bresp_r;         // Write response code.
    // AXI read side.
    logic                  arready_r;       // Read address channel ready.
    logic                  rvalid_r;        // Read data valid.
    logic [AXI_DATA_W-1:0] rdata_r;         // Read data.
    logic [1:0]            rresp_r;         // Read response code.
    // Internal strobes.
    logic                  rc_tick;         // One tick of the RC time base.
    logic                  wr_go;           // Held write is performed this cycle.
    logic                  wr_hit;          // Held write address is mapped.
    logic                  ctrl_wr;         // Control register is written this cycle.
    logic                  cmd_clear;       // Clear-watchdog instruction strobe.
    logic                  cmd_sleep;       // Sleep instruction strobe.
    logic                  restart;         // Counter and postscaler restart.
    logic                  base_done;       // One base period has elapsed.
    logic                  expiry;          // Full watchdog timeout.
    logic [PS_SEL_W-1:0]   ps_sel_eff;      // Ratio select after assignment.
    logic [PS_W-1:0]       ps_count;        // Postscaler count, for visibility.
    logic [AXI_DATA_W-1:0] rd_mux;          // Read data before registering.
    logic                  rd_hit;          // Read address is mapped.

    // The RC time base runs from reset on, whatever the processor does.
    rc_tick_divider u_rc_tick_divider (
        .clock   (clock),
        .reset_n (reset_n),
        .rc_tick (rc_tick)
    );

    // The fuse pin passes two flip-flops before anything uses it.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fuse_meta_r <= 1'b0;
            fuse_r      <= 1'b0;
        end else begin
            fuse_meta_r <= watchdog_enable_fuse;
            fuse_r      <= fuse_meta_r;
        end
    end

    // Write decoding: commands are single-cycle strobes from the low byte.
    assign wr_go     = aw_held_r && w_held_r && !bvalid_r;
    assign wr_hit    = (waddr_r == OFS_CTRL) || (waddr_r == OFS_CMD) ||
                       (waddr_r == OFS_STATUS) || (waddr_r == OFS_COUNT);
    assign ctrl_wr   = wr_go && (waddr_r == OFS_CTRL) && wstrb_r[0];
    assign cmd_clear = wr_go && (waddr_r == OFS_CMD) && wstrb_r[0] && wdata_r[CMD_CLEAR_BIT];
    assign cmd_sleep = wr_go && (waddr_r == OFS_CMD) && wstrb_r[0] && wdata_r[CMD_SLEEP_BIT];

    // A base period ends when the last tick arrives and no clear or sleep command is pending.
    assign base_done = fuse_r && rc_tick && !cmd_clear && !cmd_sleep &&
                       (tick_count_r == TICK_LIMIT - TICK_W'(1));
    // Commands, a new ratio, expiry and a cleared fuse all restart the count, so a
    // ratio change can never leave the postscaler above its new limit.
    assign restart   = cmd_clear || cmd_sleep || ctrl_wr || expiry || !fuse_r;
    // An unassigned postscaler behaves as a ratio of one.
    assign ps_sel_eff = ctrl_r.ps_assign ? ctrl_r.ps_sel : RST_PS_SEL;

    // The postscaler stretches the base period by the selected ratio.
    watchdog_postscaler u_watchdog_postscaler (
        .clock   (clock),
        .reset_n (reset_n),
        .clear   (restart),
        .step    (base_done),
        .sel     (ps_sel_eff),
        .done    (expiry),
        .count   (ps_count)
    );

    // Watchdog counter in RC ticks; it is held at zero while the fuse is clear.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tick_count_r <= '0;
        end else if (restart || base_done) begin
            tick_count_r <= '0;
        end else if (rc_tick) begin
            tick_count_r <= tick_count_r + TICK_W'(1);
        end
    end

    // Run state follows the sleep command and leaves sleep on any wake.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_RUN;
        end else begin
            unique case (state_r)
                ST_RUN: begin
                    if (cmd_sleep) begin
                        state_r <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (expiry || other_wake) begin
                        state_r <= ST_RUN;
                    end
                end
            endcase
        end
    end

    // Expiry requests a reset when running and a wake when asleep.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reset_out_r <= 1'b0;
            wake_out_r  <= 1'b0;
        end else begin
            reset_out_r <= expiry && (state_r == ST_RUN);
            wake_out_r  <= expiry && (state_r == ST_SLEEP);
        end
    end

    // The timeout flag is set only by power-on reset and cleared by expiry.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            timeout_flag_r <= RST_TIMEOUT;
        end else if (expiry) begin
            timeout_flag_r <= 1'b0;
        end
    end

    // Control register write, low byte only.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r.ps_assign <= RST_PS_ASSIGN;
            ctrl_r.ps_sel    <= RST_PS_SEL;
        end else if (ctrl_wr) begin
            ctrl_r.ps_assign <= wdata_r[CTRL_PS_ASSIGN_BIT];
            ctrl_r.ps_sel    <= wdata_r[CTRL_PS_SEL_LSB +: PS_SEL_W];
        end
    end

    // Write address and data are taken independently and held until performed.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            waddr_r   <= 8'h00;
            wdata_r   <= '0;
            wstrb_r   <= 4'h0;
        end else begin
            // Address channel.
            if (awvalid && awready_r) begin
                aw_held_r <= 1'b1;
                awready_r <= 1'b0;
                waddr_r   <= {awaddr[7:2], 2'b00};
            end else if (wr_go) begin
                aw_held_r <= 1'b0;
            end else if (bvalid_r && bready) begin
                awready_r <= 1'b1;
            end
            // Data channel.
            if (wvalid && wready_r) begin
                w_held_r <= 1'b1;
                wready_r <= 1'b0;
                wdata_r  <= wdata;
                wstrb_r  <= wstrb;
            end else if (wr_go) begin
                w_held_r <= 1'b0;
            end else if (bvalid_r && bready) begin
                wready_r <= 1'b1;
            end
        end
    end

    // Write response: unmapped addresses answer with a slave error.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Read multiplexer; the command register reads as zero.
    always_comb begin
        rd_mux = '0;
        rd_hit = 1'b1;
        unique case ({araddr[7:2], 2'b00})
            OFS_CTRL: begin
                rd_mux[CTRL_PS_ASSIGN_BIT]             = ctrl_r.ps_assign;
                rd_mux[CTRL_PS_SEL_LSB +: PS_SEL_W]    = ctrl_r.ps_sel;
            end
            OFS_CMD: begin
                rd_mux = '0;
            end
            OFS_STATUS: begin
                rd_mux[STAT_TIMEOUT_BIT] = timeout_flag_r;
                rd_mux[STAT_ASLEEP_BIT]  = (state_r == ST_SLEEP);
                rd_mux[STAT_FUSE_BIT]    = fuse_r;
            end
            OFS_COUNT: begin
                rd_mux[TICK_W-1:0]              = tick_count_r;
                rd_mux[AXI_DATA_W-1 -: PS_W]    = ps_count;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read channel: one read at a time, answered the cycle after acceptance.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= '0;
            rresp_r   <= RESP_OKAY;
        end else if (arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_mux;
            rresp_r   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && rready) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
        end
    end

    // Outputs come straight from flip-flops.
    assign awready        = awready_r;
    assign wready         = wready_r;
    assign bvalid         = bvalid_r;
    assign bresp          = bresp_r;
    assign arready        = arready_r;
    assign rvalid         = rvalid_r;
    assign rdata          = rdata_r;
    assign rresp          = rresp_r;
    assign watchdog_reset = reset_out_r;
    assign watchdog_wake  = wake_out_r;

    // A cleared fuse blocks expiry and empties both counters one cycle later.
    AST_FUSE_OFF_QUIET: assert property (
        @(posedge clock) disable iff (!reset_n)
        !fuse_r |-> !expiry ##1 (tick_count_r == '0 && ps_count == '0 &&
                                 !watchdog_reset && !watchdog_wake))
        else $error("watchdog active while fuse clear");

    // Expiry while running gives a one-cycle reset request and no wake.
    AST_RESET_WHEN_RUNNING: assert property (
        @(posedge clock) disable iff (!reset_n)
        expiry && state_r == ST_RUN |=> watchdog_reset && !watchdog_wake ##1 !watchdog_reset)
        else $error("no reset after expiry while running");

    // Expiry while asleep wakes, returns to run and never resets.
    AST_WAKE_WHEN_ASLEEP: assert property (
        @(posedge clock) disable iff (!reset_n)
        expiry && state_r == ST_SLEEP |=> watchdog_wake && !watchdog_reset && state_r == ST_RUN)
        else $error("no wake after expiry while asleep");

    // Each expiry leaves the timeout flag clear.
    AST_FLAG_CLEARED: assert property (
        @(posedge clock) disable iff (!reset_n)
        expiry |=> !timeout_flag_r)
        else $error("timeout flag not cleared by expiry");

    // Once clear, the flag stays clear until the next power-on reset.
    AST_FLAG_ONLY_BY_POR: assert property (
        @(posedge clock) disable iff (!reset_n)
        !timeout_flag_r |=> !timeout_flag_r)
        else $error("timeout flag set without power-on reset");

    // A command empties both counters and blocks expiry in that cycle.
    AST_CMD_RESTARTS: assert property (
        @(posedge clock) disable iff (!reset_n)
        (cmd_clear || cmd_sleep) |-> !expiry ##1 (tick_count_r == '0 && ps_count == '0))
        else $error("command did not restart the watchdog");

    // After an expiry both counters start again from zero.
    AST_RESTART_AFTER_EXPIRY: assert property (
        @(posedge clock) disable iff (!reset_n)
        expiry |=> (tick_count_r == '0 && ps_count == '0))
        else $error("counters not restarted after expiry");

    // Unassigned postscaler: every base period is an expiry.
    AST_RATIO_ONE: assert property (
        @(posedge clock) disable iff (!reset_n)
        !ctrl_r.ps_assign |-> (expiry == base_done))
        else $error("unassigned postscaler is not one to one");

    // The postscaler count stays below the selected ratio.
    AST_PS_BOUND: assert property (
        @(posedge clock) disable iff (!reset_n)
        ps_count <= PS_W'((8'h01 << ps_sel_eff) - 8'h01))
        else $error("postscaler count beyond ratio");

    // The tick counter never passes the base period.
    AST_BASE_BOUND: assert property (
        @(posedge clock) disable iff (!reset_n)
        tick_count_r < TICK_LIMIT)
        else $error("tick counter beyond base period");

    // The time base keeps ticking while asleep.
    AST_TICK_IN_SLEEP: assert property (
        @(posedge clock) disable iff (!reset_n)
        rc_tick |=> !rc_tick ##15 rc_tick)
        else $error("time base stalled");

endmodule : watchdog_timeout_unit
`default_nettype wire

// ### core/wdt_postscaler.sv
// Power-of-two postscaler that stretches the watchdog base period.
`timescale 1ns/1ns
`default_nettype none
module watchdog_postscaler
    import watchdog_pkg::*;
(
    // Clock and reset.
    input  wire logic                clock,
    input  wire logic                reset_n,
    // Control from the watchdog core.
    input  wire logic                clear,
    input  wire logic                step,
    input  wire logic [PS_SEL_W-1:0] sel,
    // Status back to the watchdog core.
    output logic                     done,
    output logic [PS_W-1:0]          count
);

    logic [PS_W-1:0] cnt_r;  // Base periods counted so far.
    logic [PS_W-1:0] limit;  // Last count value before the ratio is met.

    // A ratio of 2 to the power sel ends at a count of all ones in sel bits.
    assign limit = PS_W'((8'h01 << sel) - 8'h01);
    assign done  = step && (cnt_r == limit);
    assign count = cnt_r;

    // Clearing takes priority so commands always restart the whole chain.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= '0;
        end else if (clear || done) begin
            cnt_r <= '0;
        end else if (step) begin
            cnt_r <= cnt_r + PS_W'(1);
        end
    end

endmodule : watchdog_postscaler
`default_nettype wire

// ### dv/tb_watchdog_timeout_unit.sv
// Self-checking bench for the watchdog timeout unit.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb_watchdog_timeout_unit import watchdog_pkg::*;;
    // Bus, fuse and watchdog action signals.
    logic        clock, reset_n, fuse, awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic        awready, wready, bvalid, arready, rvalid, wd_rst, wd_wake;
    logic [1:0]  bresp, rresp;
    // Expected results as {data, resp}, oldest first.
    logic [33:0] exp_q[$];
    logic [33:0] got, exp_e;
    int          num_errors = 0, checks = 0, seed = 32'h09ccbdef, n;

    // A short base period of 20 ticks keeps the longest ratio affordable.
    watchdog_timeout_unit #(.BASE_TIMEOUT_CYCLES(320)) uut (
        .clock(clock), .reset_n(reset_n), .watchdog_enable_fuse(fuse), .other_wake(1'b0),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .watchdog_reset(wd_rst), .watchdog_wake(wd_wake));

    // The 25 MHz clock.
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Prints the counts and the verdict, then stops the run.
    task automatic test_done;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    // Ends the run when a wait has used up its bound.
    task automatic bail(input int lim);
        if (n > lim) begin
            num_errors++;
            $display("ERROR %0t: timeout", $time);
            test_done();
        end
    endtask : bail

    // One AXI write; random upper data bits must be ignored.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        logic [31:0] rnd;
        rnd = $random(seed);
        exp_q.push_back({32'h0, r});
        @(posedge clock);
        awaddr  <= {24'h0, a};
        wdata   <= {rnd[31:8], d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
            bail(60);
        end while (!bvalid);
        bready <= 1'b0;
    endtask : wr

    // One AXI read with its expected word.
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_q.push_back({d, r});
        @(posedge clock);
        araddr  <= {24'h0, a};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
            n++;
            bail(60);
        end while (!rvalid);
        rready <= 1'b0;
    endtask : rd

    // Waits for a reset or wake pulse and checks when it came; tick phase allows slack.
    task automatic pulse(input int cyc, input logic wake);
        exp_q.push_back({30'h0, wake, ~wake, 2'h0});
        n = 0;
        do begin
            @(posedge clock);
            n++;
            bail(cyc + 60);
        end while (!(wd_rst | wd_wake));
        `CHK(n >= cyc - 24 && n <= cyc + 24, 1'b1)
    endtask : pulse

    // Compares every result that appears with the oldest expectation.
    always @(posedge clock) begin
        if (reset_n && ((bvalid && bready) || (rvalid && rready) || wd_rst || wd_wake)) begin
            got = (rvalid && rready) ? {rdata, rresp} :
                  (bvalid && bready) ? {32'h0, bresp} : {30'h0, wd_wake, wd_rst, 2'h0};
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("ERROR %0t: unexpected result %h", $time, got);
            end else begin
                exp_e = exp_q.pop_front();
                `CHK(got, exp_e)
            end
        end
    end

    // Main sequence.
    initial begin
        reset_n = 1'b0;
        fuse    = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, wdata, araddr} = 96'h0;
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd(OFS_STATUS, 32'h5, RESP_OKAY);
        rd(OFS_CTRL, 32'h0, RESP_OKAY);
        rd(8'h10, 32'h0, RESP_SLVERR);
        wr(8'h10, 8'h01, RESP_SLVERR);
        $display("test map done");
        wr(OFS_CMD, 8'h01, RESP_OKAY);
        pulse(320, 1'b0);
        rd(OFS_STATUS, 32'h4, RESP_OKAY);
        repeat (6) begin
            repeat (200) @(posedge clock);
            wr(OFS_CMD, 8'h01, RESP_OKAY);
        end
        wr(OFS_CMD, 8'h02, RESP_OKAY);
        rd(OFS_STATUS, 32'h6, RESP_OKAY);
        pulse(316, 1'b1);
        pulse(320, 1'b0);
        $display("test sleep done");
        for (int s = 0; s < 8; s++) begin
            wr(OFS_CTRL, {4'h0, s[2:0], 1'b1}, RESP_OKAY);
            wr(OFS_CMD, 8'h01, RESP_OKAY);
            pulse(320 << s, 1'b0);
        end
        wr(OFS_CTRL, 8'h0e, RESP_OKAY);
        wr(OFS_CMD, 8'h01, RESP_OKAY);
        pulse(320, 1'b0);
        $display("test postscaler done");
        fuse <= 1'b0;
        wr(OFS_CMD, 8'h01, RESP_OKAY);
        repeat (1500) @(posedge clock);
        rd(OFS_STATUS, 32'h0, RESP_OKAY);
        $display("test fuse done");
        test_done();
    end
endmodule : tb_watchdog_timeout_unit
`default_nettype wire
